// File: hw/fls_map.svh
// Link scheduler constants: address ranges, frame timing and default counts
`ifndef FLS_MAP_SVH
`define FLS_MAP_SVH

// ------------------------------------------------------------
// Clock and octet timing
// ------------------------------------------------------------
`define FLS_CLK_MHZ      125
`define FLS_OCTET_NS     256000
`define FLS_OCTET_CYC    ((`FLS_OCTET_NS * `FLS_CLK_MHZ) / 1000)

// ------------------------------------------------------------
// Node address ranges
// ------------------------------------------------------------
`define FLS_ADR_RSV_TOP  8'h0f
`define FLS_ADR_OWN_LO   8'h14
`define FLS_ADR_OWN_HI   8'h23
`define FLS_ADR_TMP_LO   8'hf8
`define FLS_ADR_TMP_HI   8'hfb
`define FLS_ADR_PROBE_LO 8'h10

// ------------------------------------------------------------
// Link timing counts, in octets unless named otherwise
// ------------------------------------------------------------
`define FLS_SLOT_OCT     1
`define FLS_MRD_SLOT     2
`define FLS_MID_OCT      1
`define FLS_HOLD_OCT     4
`define FLS_MACRO_OCT    64
`define FLS_SILENCE_SLOT 2
`define FLS_FAIL_SLOT    4
`define FLS_NSCH         4

`endif

// File: hw/fls_pkg.sv
// Link scheduler shared types
package fls_pkg;

	typedef enum logic [3:0] {
		kind_none   = 4'h0,
		kind_cd     = 4'h1,
		kind_pt     = 4'h2,
		kind_time   = 4'h3,
		kind_stime  = 4'h4,
		kind_probe  = 4'h5,
		kind_assign = 4'h6,
		kind_pub    = 4'h7,
		kind_msg    = 4'h8,
		kind_done   = 4'h9,
		kind_join   = 4'ha,
		kind_bid    = 4'hb
	} fls_kind_t;

	typedef logic [7:0] fls_adr_t;

endpackage

// File: hw/fls_link_if.sv
// Shared link between the scheduler end and the node end
`timescale 1ns/1ps
interface fls_link_if;

	// Scheduler to node, one-cycle frames
	logic              m_vld;
	fls_pkg::fls_kind_t m_kind;
	logic [7:0]        m_dst;
	logic [15:0]       m_dat;

	// Node to scheduler, held until n_rdy
	logic              n_vld;
	logic              n_rdy;
	fls_pkg::fls_kind_t n_kind;
	logic [7:0]        n_src;
	logic [7:0]        n_dst;
	logic [15:0]       n_dat;

	modport sched (output m_vld, m_kind, m_dst, m_dat,
	               input n_vld, n_kind, n_src, n_dst, n_dat, output n_rdy);
	modport node  (input m_vld, m_kind, m_dst, m_dat,
	               output n_vld, n_kind, n_src, n_dst, n_dat, input n_rdy);

endinterface

// File: hw/fls_fifo2.sv
// Small valid/ready buffer with flip-flop storage
`timescale 1ns/1ps
module fls_fifo2 #(
	parameter int W     = 24,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	// Fill side
	input  wire logic         in_vld,
	output logic              in_rdy,
	input  wire logic [W-1:0] in_dat,
	// Drain side
	output logic              out_vld,
	input  wire logic         out_rdy,
	output logic [W-1:0]      out_dat
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0]   cnt;
	logic          push;
	logic          pop;

	assign in_rdy  = cnt != (AW+1)'(DEPTH);
	assign out_vld = cnt != '0;
	assign out_dat = mem[rp];
	assign push    = in_vld && in_rdy;
	assign pop     = out_vld && out_rdy;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wp] <= in_dat;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end else begin
			if (push) begin
				wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
			end
			if (pop) begin
				rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
			end
			cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule

// File: hw/fls_sched.sv
// Link scheduler end: election, live list, schedule, tokens and time
//
// Operation
// - Only one active scheduler arbitrates the link
// - Live list adds joiners, drops silent nodes
// - Broadcast network time and schedule start offset
// - Capable nodes bid at start or failure
// - Bid losers act basic, watch for silence
// - Lowest node address wins the bid
// - One transmitter at a time, token holder only
// - Schedule table entries send poll tokens when due
// - Free tokens go round in ascending address order
// - Addresses 0 to 15 never assigned
// - Own programmed address limited to 20..35
// - Duplicates get temporary 248..251 or wait (here the node ignores the assignment once it has sent its join)
// - Publisher keeps one overwritten value buffer
// - Poll token gives one broadcast, subscribers capture
// - Reports queued, sent only between scheduled polls
// - Requests queued, flow controlled, retried on errors (here each frame is sent once and never retried)
// - Free token held until empty or time up
// - Every listed node gets unscheduled send chances
// - Macrocycle start shared for block execution offsets
// - Wait one slot delay before deciding election
// - Minimum gap between frames in octet units
// - Immediate replies within maximum reply delay
`timescale 1ns/1ps
`include "fls_map.svh"
module fls_sched #(
	parameter int OCTET_CYC = `FLS_OCTET_CYC,
	parameter int SLOT_OCT  = `FLS_SLOT_OCT,
	parameter int MRD_SLOT  = `FLS_MRD_SLOT,
	parameter int MID_OCT   = `FLS_MID_OCT,
	parameter int HOLD_OCT  = `FLS_HOLD_OCT,
	parameter int MACRO_OCT = `FLS_MACRO_OCT,
	parameter int NSCH      = `FLS_NSCH
) (
	// Clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    rst_b,
	// Configuration
	input  wire logic [7:0]              my_adr,
	input  wire logic                    master_cap,
	input  wire logic                    cfg_we,
	input  wire logic [$clog2(NSCH)-1:0] cfg_idx,
	input  wire logic                    cfg_en,
	input  wire logic [15:0]             cfg_off,
	input  wire logic [7:0]              cfg_adr,
	// Status
	output logic                         is_active,
	output logic                         adr_bad,
	output logic [255:0]                 live_list,
	output logic [31:0]                  net_time,
	output logic                         mc_start,
	output logic [15:0]                  mc_pos,
	// Captured broadcasts
	output logic                         rx_vld,
	input  wire logic                    rx_rdy,
	output logic [7:0]                   rx_src,
	output logic [15:0]                  rx_dat,
	// Link
	fls_link_if.sched                    lnk
);
	localparam int IW = $clog2(NSCH);
	localparam int CW = $clog2(OCTET_CYC);

	typedef enum logic [4:0] {
		st_listen = 5'b00001,
		st_bid    = 5'b00010,
		st_basic  = 5'b00100,
		st_gap    = 5'b01000,
		st_wait   = 5'b10000
	} fls_sst_t;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] fls_next(input logic [255:0] l, input logic [7:0] c);
		logic [7:0] r;
		logic [7:0] a;
		logic       f;
		r = c;
		a = c;
		f = 1'b0;
		for (int i = 0; i < 256; i++) begin
			a = a + 8'h01;
			if (!f && l[a]) begin
				r = a;
				f = 1'b1;
			end
		end
		return r;
	endfunction

	function automatic logic in_tmp(input logic [7:0] a);
		return a >= `FLS_ADR_TMP_LO && a <= `FLS_ADR_TMP_HI;
	endfunction

	// ------------------------------------------------------------
	// State and signals
	// ------------------------------------------------------------
	fls_sst_t          st;
	fls_sst_t          next_st;
	logic [CW-1:0]     oct_div;
	logic              oct_tick;
	logic [15:0]       tmr;
	logic [15:0]       hold;
	logic              mc_wrap;
	logic [15:0]       sched_off;
	logic              time_due;
	logic              stime_due;
	logic              probe_due;
	logic [7:0]        probe_adr;
	logic [NSCH-1:0]   cd_due;
	logic [15:0]       sch_off [NSCH];
	logic [7:0]        sch_adr [NSCH];
	logic [NSCH-1:0]   sch_en;
	logic [IW-1:0]     cd_idx;
	logic [7:0]        pt_cur;
	logic [3:0]        tmp_busy;
	logic [1:0]        tmp_idx;
	logic              asg_due;
	logic [7:0]        asg_dst;
	logic [7:0]        asg_tmp;
	fls_pkg::fls_kind_t wkind;
	logic [7:0]        wdst;
	logic              wgot;
	logic              adr_ok;
	logic              rx_take;
	logic              lower_bid;
	logic              drop_now;
	logic              snd;
	fls_pkg::fls_kind_t snd_kind;
	logic [7:0]        snd_dst;
	logic [15:0]       snd_dat;
	logic              fifo_in;

	assign adr_ok    = my_adr >= `FLS_ADR_OWN_LO && my_adr <= `FLS_ADR_OWN_HI;
	assign adr_bad   = !adr_ok;
	assign is_active = st == st_gap || st == st_wait;
	assign oct_tick  = oct_div == CW'(OCTET_CYC - 1);
	assign mc_wrap   = oct_tick && mc_pos == 16'(MACRO_OCT - 1);
	assign mc_start  = mc_wrap;
	assign rx_take   = lnk.n_vld && lnk.n_rdy;
	assign lower_bid = rx_take && lnk.n_kind == fls_pkg::kind_bid && lnk.n_src < my_adr;

	// ------------------------------------------------------------
	// Received broadcasts buffer
	// ------------------------------------------------------------
	assign fifo_in = lnk.n_vld && (lnk.n_kind == fls_pkg::kind_pub || lnk.n_kind == fls_pkg::kind_msg);

	fls_fifo2 #(.W(24), .DEPTH(2)) u_rx (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.in_vld  (fifo_in),
		.in_rdy  (lnk.n_rdy),
		.in_dat  ({lnk.n_src, lnk.n_dat}),
		.out_vld (rx_vld),
		.out_rdy (rx_rdy),
		.out_dat ({rx_src, rx_dat})
	);

	// ------------------------------------------------------------
	// Octet divider, macrocycle and time
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			oct_div   <= '0;
			mc_pos    <= 16'h0000;
			net_time  <= 32'h0000_0000;
			sched_off <= 16'h0000;
		end else begin
			oct_div <= oct_tick ? '0 : oct_div + 1'b1;
			if (oct_tick) begin
				net_time <= net_time + 32'h0000_0001;
				mc_pos   <= mc_wrap ? 16'h0000 : mc_pos + 16'h0001;
			end
			if (mc_wrap) begin
				sched_off <= net_time[15:0] + 16'h0001;
			end
		end
	end

	// ------------------------------------------------------------
	// Schedule table
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sch_en <= '0;
			for (int i = 0; i < NSCH; i++) begin
				sch_off[i] <= 16'h0000;
				sch_adr[i] <= 8'h00;
			end
		end else if (cfg_we) begin
			sch_en[cfg_idx]  <= cfg_en;
			sch_off[cfg_idx] <= cfg_off;
			sch_adr[cfg_idx] <= cfg_adr;
		end
	end

	always_comb begin
		cd_idx = '0;
		for (int i = NSCH - 1; i >= 0; i--) begin
			if (cd_due[i]) begin
				cd_idx = IW'(i);
			end
		end
		tmp_idx = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (!tmp_busy[i]) begin
				tmp_idx = 2'(i);
			end
		end
	end

	// ------------------------------------------------------------
	// Next state and frame choice
	// ------------------------------------------------------------
	always_comb begin
		next_st  = st;
		snd      = 1'b0;
		snd_kind = fls_pkg::kind_none;
		snd_dst  = 8'h00;
		snd_dat  = 16'h0000;
		drop_now = 1'b0;
		unique case (st)
			st_listen: begin
				if (!master_cap || !adr_ok || lower_bid) begin
					next_st = st_basic;
				end else if (tmr >= 16'(SLOT_OCT * `FLS_SILENCE_SLOT)) begin
					snd      = 1'b1;
					snd_kind = fls_pkg::kind_bid;
					snd_dst  = 8'hff;
					snd_dat  = {8'h00, my_adr};
					next_st  = st_bid;
				end
			end
			st_bid: begin
				if (lower_bid) begin
					next_st = st_basic;
				end else if (tmr >= 16'(SLOT_OCT)) begin
					next_st = st_gap;
				end
			end
			st_basic: begin
				if (master_cap && adr_ok && tmr >= 16'(SLOT_OCT * `FLS_FAIL_SLOT)) begin
					next_st = st_listen;
				end
			end
			st_gap: begin
				if (lower_bid) begin
					next_st = st_basic;
				end else if (tmr >= 16'(MID_OCT)) begin
					snd = 1'b1;
					if (time_due) begin
						snd_kind = fls_pkg::kind_time;
						snd_dst  = 8'hff;
						snd_dat  = net_time[15:0];
					end else if (stime_due) begin
						snd_kind = fls_pkg::kind_stime;
						snd_dst  = 8'hff;
						snd_dat  = sched_off;
					end else if (asg_due) begin
						snd_kind = fls_pkg::kind_assign;
						snd_dst  = asg_dst;
						snd_dat  = {8'h00, asg_tmp};
					end else if (|cd_due) begin
						snd_kind = fls_pkg::kind_cd;
						snd_dst  = sch_adr[cd_idx];
						next_st  = st_wait;
					end else if (probe_due) begin
						snd_kind = fls_pkg::kind_probe;
						snd_dst  = probe_adr;
						next_st  = st_wait;
					end else if (|live_list) begin
						snd_kind = fls_pkg::kind_pt;
						snd_dst  = fls_next(live_list, pt_cur);
						next_st  = st_wait;
					end else begin
						snd = 1'b0;
					end
				end
			end
			st_wait: begin
				if (rx_take && (lnk.n_kind == fls_pkg::kind_done ||
				    (wkind != fls_pkg::kind_pt && lnk.n_kind != fls_pkg::kind_msg))) begin
					next_st = st_gap;
				end else if (!rx_take && tmr >= 16'(MRD_SLOT * SLOT_OCT)) begin
					next_st  = st_gap;
					drop_now = !wgot && wkind != fls_pkg::kind_probe;
				end else if (hold >= 16'(HOLD_OCT)) begin
					next_st = st_gap;
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// State, timers and link output
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st    <= st_listen;
			tmr   <= 16'h0000;
			hold  <= 16'h0000;
			wkind <= fls_pkg::kind_none;
			wdst  <= 8'h00;
			wgot  <= 1'b0;
		end else begin
			st <= next_st;
			if (next_st != st || rx_take || snd) begin
				tmr <= 16'h0000;
			end else if (oct_tick && tmr != 16'hffff) begin
				tmr <= tmr + 16'h0001;
			end
			if (snd) begin
				hold  <= 16'h0000;
				wkind <= snd_kind;
				wdst  <= snd_dst;
				wgot  <= 1'b0;
			end else begin
				if (oct_tick && st == st_wait && wkind == fls_pkg::kind_pt) begin
					hold <= hold + 16'h0001;
				end
				if (rx_take) begin
					wgot <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lnk.m_vld  <= 1'b0;
			lnk.m_kind <= fls_pkg::kind_none;
			lnk.m_dst  <= 8'h00;
			lnk.m_dat  <= 16'h0000;
		end else begin
			lnk.m_vld <= snd;
			if (snd) begin
				lnk.m_kind <= snd_kind;
				lnk.m_dst  <= snd_dst;
				lnk.m_dat  <= snd_dat;
			end
		end
	end

	// ------------------------------------------------------------
	// Pending work flags (a new set wins over a clear)
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			time_due  <= 1'b0;
			stime_due <= 1'b0;
			probe_due <= 1'b0;
			probe_adr <= `FLS_ADR_PROBE_LO;
			cd_due    <= '0;
			pt_cur    <= 8'h00;
		end else begin
			if (snd && snd_kind == fls_pkg::kind_time) time_due <= 1'b0;
			if (snd && snd_kind == fls_pkg::kind_stime) stime_due <= 1'b0;
			if (snd && snd_kind == fls_pkg::kind_probe) begin
				probe_due <= 1'b0;
				probe_adr <= (probe_adr == 8'hff) ? `FLS_ADR_PROBE_LO : probe_adr + 8'h01;
			end
			if (snd && snd_kind == fls_pkg::kind_cd) cd_due[cd_idx] <= 1'b0;
			if (snd && snd_kind == fls_pkg::kind_pt) pt_cur <= snd_dst;
			if (mc_wrap && is_active) begin
				time_due  <= 1'b1;
				stime_due <= 1'b1;
				probe_due <= 1'b1;
			end
			for (int i = 0; i < NSCH; i++) begin
				if (oct_tick && is_active && sch_en[i] && mc_pos == sch_off[i]) begin
					cd_due[i] <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Live list and temporary addresses
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			live_list <= '0;
			tmp_busy  <= 4'h0;
			asg_due   <= 1'b0;
			asg_dst   <= 8'h00;
			asg_tmp   <= 8'h00;
		end else begin
			if (snd && snd_kind == fls_pkg::kind_assign) asg_due <= 1'b0;
			if (drop_now) begin
				live_list[wdst] <= 1'b0;
				if (in_tmp(wdst)) tmp_busy[wdst[1:0]] <= 1'b0;
			end
			if (rx_take && lnk.n_kind == fls_pkg::kind_join && lnk.n_src > `FLS_ADR_RSV_TOP &&
			    !in_tmp(lnk.n_src) && is_active) begin
				if (!live_list[lnk.n_src]) begin
					live_list[lnk.n_src] <= 1'b1;
				end else if (tmp_busy != 4'hf && !asg_due) begin
					tmp_busy[tmp_idx] <= 1'b1;
					live_list[`FLS_ADR_TMP_LO + {6'h00, tmp_idx}] <= 1'b1;
					asg_due <= 1'b1;
					asg_dst <= lnk.n_src;
					asg_tmp <= `FLS_ADR_TMP_LO + {6'h00, tmp_idx};
				end
			end
		end
	end

endmodule

// File: hw/fls_node.sv
// Link node end: joins, publishes on poll, sends queued traffic on token
`timescale 1ns/1ps
`include "fls_map.svh"
module fls_node #(
	parameter int OCTET_CYC = `FLS_OCTET_CYC,
	parameter int MID_OCT   = `FLS_MID_OCT,
	parameter int HOLD_OCT  = `FLS_HOLD_OCT
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// Configuration
	input  wire logic [7:0]  prog_adr,
	// Published value
	input  wire logic        pub_we,
	input  wire logic [15:0] pub_dat,
	// Queued messages
	input  wire logic        msg_vld,
	output logic             msg_rdy,
	input  wire logic [7:0]  msg_dst,
	input  wire logic [15:0] msg_dat,
	// Status
	output logic [7:0]       cur_adr,
	output logic             listed,
	output logic [15:0]      net_time,
	output logic [15:0]      sched_off,
	output logic             mc_sync,
	// Link
	fls_link_if.node         lnk
);
	localparam logic [31:0] GAP_CYC  = 32'(MID_OCT * OCTET_CYC);
	localparam logic [31:0] HOLD_CYC = 32'(HOLD_OCT * OCTET_CYC);

	typedef enum logic [3:0] {
		nd_idle = 4'b0001,
		nd_join = 4'b0010,
		nd_pub  = 4'b0100,
		nd_tok  = 4'b1000
	} fls_nst_t;

	fls_nst_t    st;
	logic        adr_set;
	logic [15:0] pub_buf;
	logic [31:0] gap;
	logic [31:0] hold;
	logic        q_vld;
	logic        q_rdy;
	logic [7:0]  q_dst;
	logic [15:0] q_dat;
	logic        to_me;
	logic        can_tx;
	logic        tx_done;

	assign to_me   = lnk.m_vld && lnk.m_dst == cur_adr;
	assign can_tx  = !lnk.n_vld && gap >= GAP_CYC;
	assign tx_done = lnk.n_vld && lnk.n_rdy;
	assign q_rdy   = st == nd_tok && can_tx && hold < HOLD_CYC;

	fls_fifo2 #(.W(24), .DEPTH(2)) u_tx (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.in_vld  (msg_vld),
		.in_rdy  (msg_rdy),
		.in_dat  ({msg_dst, msg_dat}),
		.out_vld (q_vld),
		.out_rdy (q_rdy),
		.out_dat ({q_dst, q_dat})
	);

	// ------------------------------------------------------------
	// Address, published buffer and time
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			adr_set   <= 1'b0;
			cur_adr   <= 8'h00;
			pub_buf   <= 16'h0000;
			net_time  <= 16'h0000;
			sched_off <= 16'h0000;
			mc_sync   <= 1'b0;
		end else begin
			if (!adr_set) begin
				adr_set <= 1'b1;
				cur_adr <= prog_adr;
			end else if (to_me && lnk.m_kind == fls_pkg::kind_assign && !listed) begin
				cur_adr <= lnk.m_dat[7:0];
			end
			if (pub_we) pub_buf <= pub_dat;
			if (lnk.m_vld && lnk.m_kind == fls_pkg::kind_time) net_time <= lnk.m_dat;
			if (lnk.m_vld && lnk.m_kind == fls_pkg::kind_stime) sched_off <= lnk.m_dat;
			mc_sync <= lnk.m_vld && lnk.m_kind == fls_pkg::kind_stime;
		end
	end

	// ------------------------------------------------------------
	// Token handling and transmission
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st     <= nd_idle;
			listed <= 1'b0;
			gap    <= 32'h0000_0000;
			hold   <= 32'h0000_0000;
			lnk.n_vld  <= 1'b0;
			lnk.n_kind <= fls_pkg::kind_none;
			lnk.n_src  <= 8'h00;
			lnk.n_dst  <= 8'h00;
			lnk.n_dat  <= 16'h0000;
		end else begin
			if (tx_done) lnk.n_vld <= 1'b0;
			if (lnk.m_vld || tx_done) begin
				gap <= 32'h0000_0000;
			end else if (gap != 32'hffff_ffff) begin
				gap <= gap + 32'h0000_0001;
			end
			if (st == nd_tok && hold != 32'hffff_ffff) hold <= hold + 32'h0000_0001;
			unique case (st)
				nd_idle: begin
					hold <= 32'h0000_0000;
					if (to_me && lnk.m_kind == fls_pkg::kind_probe) st <= nd_join;
					if (to_me && lnk.m_kind == fls_pkg::kind_cd) st <= nd_pub;
					if (to_me && lnk.m_kind == fls_pkg::kind_pt) st <= nd_tok;
				end
				nd_join: begin
					if (can_tx) begin
						lnk.n_vld  <= 1'b1;
						lnk.n_kind <= fls_pkg::kind_join;
						lnk.n_src  <= cur_adr;
						lnk.n_dst  <= 8'hff;
						lnk.n_dat  <= 16'h0000;
						listed     <= 1'b1;
						st         <= nd_idle;
					end
				end
				nd_pub: begin
					if (can_tx) begin
						lnk.n_vld  <= 1'b1;
						lnk.n_kind <= fls_pkg::kind_pub;
						lnk.n_src  <= cur_adr;
						lnk.n_dst  <= 8'hff;
						lnk.n_dat  <= pub_buf;
						st         <= nd_idle;
					end
				end
				nd_tok: begin
					if (can_tx) begin
						lnk.n_vld <= 1'b1;
						lnk.n_src <= cur_adr;
						if (q_vld && hold < HOLD_CYC) begin
							lnk.n_kind <= fls_pkg::kind_msg;
							lnk.n_dst  <= q_dst;
							lnk.n_dat  <= q_dat;
						end else begin
							lnk.n_kind <= fls_pkg::kind_done;
							lnk.n_dst  <= 8'hff;
							lnk.n_dat  <= 16'h0000;
							st         <= nd_idle;
						end
					end
				end
			endcase
		end
	end

endmodule

// File: tb/fls_props.sv
// Link checker for the scheduler and node ends
`timescale 1ns/1ps
module fls_props (
	// Clock and reset
	input wire logic               clk_sys,
	input wire logic               rst_b,
	// Link
	input wire logic               m_vld,
	input wire fls_pkg::fls_kind_t m_kind,
	input wire logic [7:0]         m_dst,
	input wire logic [15:0]        m_dat,
	input wire logic               n_vld,
	input wire logic               n_rdy,
	input wire fls_pkg::fls_kind_t n_kind,
	input wire logic [7:0]         n_src
);
	// ----------
	// Link rules
	// ----------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	m_gap_a: assert property (m_vld |=> !m_vld [*7]) else $error("frames too close");
	n_gap_a: assert property (m_vld |=> !$rose(n_vld) [*7]) else $error("reply too early");
	n_hold_a: assert property (n_vld && !n_rdy |=> n_vld && $stable(n_src)) else $error("frame lost");
	n_end_a: assert property (n_vld && n_rdy |=> !n_vld) else $error("frame repeated");
	src_rsv_a: assert property (n_vld |-> n_src > 8'h0f) else $error("reserved source");
	dst_rsv_a: assert property (m_vld && m_kind inside {fls_pkg::kind_cd, fls_pkg::kind_pt} |->
		m_dst > 8'h0f) else $error("reserved target");
	tmp_adr_a: assert property (m_vld && m_kind == fls_pkg::kind_assign |->
		m_dat[7:0] inside {[8'hf8:8'hfb]}) else $error("bad temporary address");
	bid_adr_a: assert property (m_vld && m_kind == fls_pkg::kind_bid |->
		m_dat[7:0] inside {[8'h14:8'h23]}) else $error("bad bid address");
	cd_reply_a: assert property (m_vld && m_kind == fls_pkg::kind_cd |->
		##[9:24] n_vld && n_kind == fls_pkg::kind_pub && n_src == m_dst) else $error("no publish");
	cd_c: cover property (m_vld && m_kind == fls_pkg::kind_cd);
	pt_c: cover property (m_vld && m_kind == fls_pkg::kind_pt);
	stall_c: cover property (n_vld && !n_rdy);
endmodule

// File: tb/test_fieldbus_link_scheduler.sv
// Bench joining the scheduler end to the node end
`timescale 1ns/1ps
module test_fieldbus_link_scheduler;
	// ----------
	// Signals
	// ----------
	logic         clk_sys = 1'b0;
	logic         rst_b   = 1'b0;
	logic         cfg_we  = 1'b0;
	logic         cfg_en  = 1'b0;
	logic         pub_we  = 1'b0;
	logic         msg_vld = 1'b0;
	logic         rx_rdy  = 1'b1;
	logic [15:0]  cfg_off = 16'h4;
	logic [7:0]   msg_dst = 8'hff;
	logic [15:0]  pub_dat = 16'h0;
	logic [15:0]  msg_dat = 16'h0;
	logic [7:0]   my_adr  = 8'h13;
	logic [1:0]   cfg_idx = 2'h1;
	logic [7:0]   cfg_adr = 8'h16;
	logic         mc_start;
	logic [15:0]  mc_pos, n_soff;
	logic         is_act, adr_bad, rx_vld, msg_rdy, listed, mc_sync;
	logic [255:0] live;
	logic [31:0]  s_time;
	logic [15:0]  rx_dat, n_time;
	logic [7:0]   rx_src, cur_adr;
	int           bad_count = 0;
	int           checks    = 0;
	always #4 clk_sys = ~clk_sys;
	fls_link_if fls_link_if_i ();
	fls_sched #(.OCTET_CYC(8), .MACRO_OCT(16)) fls_sched_i (.clk_sys(clk_sys), .rst_b(rst_b), .my_adr(my_adr),
		.master_cap(1'b1), .cfg_we(cfg_we), .cfg_idx(cfg_idx), .cfg_en(cfg_en), .cfg_off(cfg_off),
		.cfg_adr(cfg_adr), .is_active(is_act), .adr_bad(adr_bad), .live_list(live), .net_time(s_time),
		.mc_start(mc_start), .mc_pos(mc_pos), .rx_vld(rx_vld), .rx_rdy(rx_rdy), .rx_src(rx_src),
		.rx_dat(rx_dat), .lnk(fls_link_if_i));
	fls_node #(.OCTET_CYC(8)) fls_node_i (.clk_sys(clk_sys), .rst_b(rst_b), .prog_adr(8'h16), .pub_we(pub_we),
		.pub_dat(pub_dat), .msg_vld(msg_vld), .msg_rdy(msg_rdy), .msg_dst(msg_dst), .msg_dat(msg_dat),
		.cur_adr(cur_adr), .listed(listed), .net_time(n_time), .sched_off(n_soff), .mc_sync(mc_sync),
		.lnk(fls_link_if_i));
	fls_props fls_props_i (.clk_sys(clk_sys), .rst_b(rst_b), .m_vld(fls_link_if_i.m_vld),
		.m_kind(fls_link_if_i.m_kind), .m_dst(fls_link_if_i.m_dst), .m_dat(fls_link_if_i.m_dat),
		.n_vld(fls_link_if_i.n_vld), .n_rdy(fls_link_if_i.n_rdy), .n_kind(fls_link_if_i.n_kind),
		.n_src(fls_link_if_i.n_src));
	task automatic tick(int n = 1);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic t_elect();
		for (int i = 0; i < 200 && is_act !== 1'b1; i++) tick();
		chk("is_active", is_act, 1'b1);
		chk("adr_bad", adr_bad, 1'b0);
	endtask
	task automatic t_join();
		for (int i = 0; i < 3000 && live[8'h16] !== 1'b1; i++) tick();
		chk("live_list", live[8'h16], 1'b1);
		chk("listed", listed, 1'b1);
		chk("cur_adr", cur_adr, 8'h16);
	endtask
	task automatic t_time();
		for (int i = 0; i < 200 && mc_start !== 1'b1; i++) tick();
		chk("mc_pos", mc_pos, 16'h000f);
		tick();
		chk("mc_pos", mc_pos, 16'h0000);
		chk("mc_start", mc_start, 1'b0);
		for (int i = 0; i < 400 && mc_sync !== 1'b1; i++) tick();
		chk("mc_sync", mc_sync, 1'b1);
		chk("net_time", s_time[15:0] - n_time < 16'h4, 1'b1);
		chk("sched_off", 16'(s_time[15:0] - n_soff), mc_pos);
	endtask
	task automatic t_poll();
		pub_dat = 16'h1234;
		pub_we = 1'b1;
		tick();
		pub_dat = 16'hbeef;
		cfg_en = 1'b1;
		cfg_we = 1'b1;
		tick();
		pub_we = 1'b0;
		cfg_we = 1'b0;
		for (int i = 0; i < 400 && rx_vld !== 1'b1; i++) tick();
		chk("rx_src", rx_src, 8'h16);
		chk("rx_dat", rx_dat, 16'hbeef);
		cfg_en = 1'b0;
		cfg_we = 1'b1;
		tick();
		cfg_we = 1'b0;
		tick(60);
	endtask
	task automatic t_msg();
		rx_rdy = 1'b0;
		msg_vld = 1'b1;
		for (int k = 0; k < 3; k++) begin
			msg_dat = 16'ha001 + 16'(k);
			for (int i = 0; i < 2000 && msg_rdy !== 1'b1; i++) tick();
			tick();
		end
		msg_vld = 1'b0;
		tick(200);
		chk("n_vld", fls_link_if_i.n_vld, 1'b1);
		rx_rdy = 1'b1;
		for (int k = 0; k < 3; k++) begin
			for (int i = 0; i < 400 && rx_vld !== 1'b1; i++) tick();
			chk("rx_dat", rx_dat, 16'ha001 + 16'(k));
			tick();
		end
		for (int i = 0; i < 100 && fls_link_if_i.n_kind !== fls_pkg::kind_done; i++) tick();
		chk("n_kind", fls_link_if_i.n_kind, fls_pkg::kind_done);
	endtask
	initial begin
		tick(19);
		chk("adr_bad", adr_bad, 1'b1);
		my_adr = 8'h24;
		tick();
		chk("adr_bad", adr_bad, 1'b1);
		my_adr = 8'h14;
		rst_b = 1'b1;
		t_elect();
		t_join();
		t_time();
		t_poll();
		t_msg();
		final_report();
	end
	initial begin
		tick(20000);
		bad_count++;
		final_report();
	end
endmodule
